/* hdl/edge_sync.v */
`timescale 1ns/1ps
`default_nettype none

module edge_sync (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // pin and event
    input wire pin_in,
    output reg rise_pulse
);

reg sync1_reg;
reg sync2_reg;
reg prev_reg;

// pull-up: idle reset value is high, so no false edge at start
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        sync1_reg <= 1'b1;
        sync2_reg <= 1'b1;
        prev_reg <= 1'b1;
        rise_pulse <= 1'b0;
    end else begin
        sync1_reg <= pin_in;
        sync2_reg <= sync1_reg;
        prev_reg <= sync2_reg;
        rise_pulse <= sync2_reg & ~prev_reg;
    end
end

endmodule // edge_sync

`default_nettype wire

/* hdl/period_tick.v */
`timescale 1ns/1ps
`default_nettype none

module period_tick #(
    parameter integer PERIOD = 1000000
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // tick
    output reg tick
);

reg [31:0] count_reg;

always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        count_reg <= 32'h00000000;
        tick <= 1'b0;
    end else if (count_reg == PERIOD - 1) begin
        count_reg <= 32'h00000000;
        tick <= 1'b1;
    end else begin
        count_reg <= count_reg + 32'h00000001;
        tick <= 1'b0;
    end
end

endmodule // period_tick

`default_nettype wire

/* hdl/tacho_feedback_regs.vh */
`ifndef TACHO_FEEDBACK_REGS_VH
`define TACHO_FEEDBACK_REGS_VH

// apb register byte offsets
`define ADDR_CTRL 12'h000
`define ADDR_TARGET 12'h004
`define ADDR_FEEDBACK 12'h008
`define ADDR_LASTCOUNT 12'h00c
`define ADDR_SUM 12'h010

// control register fields
`define CTRL_EN_BIT 0
`define CTRL_SAMPLES_LSB 8
`define CTRL_SAMPLES_MSB 13
`define CTRL_DIVSHIFT_LSB 16
`define CTRL_DIVSHIFT_MSB 19

// reset values
`define CTRL_SAMPLES_RST 6'h01
`define CTRL_DIVSHIFT_RST 4'h0
`define TARGET_RST 12'h800
`define FEEDBACK_RST 12'h800

// feedback arithmetic
`define FB_MID 12'h800
`define FB_MAX 12'hfff
`define SAMPLES_MAX 6'h20
`define DIVSHIFT_MAX 4'hf

// timing
`define CLK_HZ 100000000
`define PERIOD_MS 10
`define PERIOD_CYCLES ((`CLK_HZ / 1000) * `PERIOD_MS)

`endif

/* hdl/tacho_pulse_count_feedback.v */
// What this block does
// RULE1: feedback is 2048 plus or minus measurement
// RULE2: add when target at least 2048, else subtract
// RULE3: clamp feedback to 0..4095, saturating
// RULE4: count tacho rising edges each control period
// RULE5: sum last N period counts, N 1..32
// RULE6: divide sum by divider before combining
// RULE7: tacho pin is digital, idles high
// RULE8: divider only powers of two 1..32768
// RULE9: two-flop synchroniser, each edge counted once
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "tacho_feedback_regs.vh"

module tacho_pulse_count_feedback #(
    parameter integer PERIOD_CYCLES = `PERIOD_CYCLES,
    parameter integer COUNT_W = 24,
    parameter integer MAX_SAMPLES = 32
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // tachometer pin
    input wire tacho_input,
    // feedback result
    output reg [11:0] feedback,
    output reg feedback_valid
);

localparam integer SUM_W = COUNT_W + 6;

wire edge_rise;
wire period_end;

edge_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pin_in(tacho_input), // [RULE7]
    .rise_pulse(edge_rise) // [RULE9]
);

period_tick #(
    .PERIOD(PERIOD_CYCLES)
) u_tick (
    .clk(clk),
    .reset_n(reset_n),
    .tick(period_end)
);

// software settings
reg enable_reg;
reg [5:0] samples_reg;
reg [3:0] divshift_reg;
reg [11:0] target_reg;

// measurement state
reg [COUNT_W-1:0] edge_count_reg;
reg [COUNT_W-1:0] last_count_reg;
reg [COUNT_W-1:0] hist [0:MAX_SAMPLES-1];
reg [4:0] wr_ptr_reg;
reg [SUM_W-1:0] sum_reg;
reg calc_reg;
// history entries written since reset; empty slots add nothing
reg [MAX_SAMPLES-1:0] filled_reg;
wire [4:0] wr_next = wr_ptr_reg + 5'h01;

// sum of newest n entries in the history ring
function [SUM_W-1:0] ring_sum;
    input [4:0] newest;
    input [5:0] n;
    integer i;
    reg [4:0] idx;
    begin
        ring_sum = {SUM_W{1'b0}};
        for (i = 0; i < MAX_SAMPLES; i = i + 1) begin
            idx = newest - i[4:0];
            if (i < n && filled_reg[idx]) begin
                ring_sum = ring_sum + {6'h00, hist[idx]};
            end
        end
    end
endfunction

// apb phases: setup decodes and answers, access commits the write
wire setup_phase = psel & ~penable;
wire access_wr = psel & penable & pready & pwrite;
wire [5:0] samples_wr = pwdata[`CTRL_SAMPLES_MSB:`CTRL_SAMPLES_LSB];
wire [3:0] divshift_wr = pwdata[`CTRL_DIVSHIFT_MSB:`CTRL_DIVSHIFT_LSB];

// sample count accepted only inside 1..32
function samples_ok;
    input [5:0] value;
    begin
        samples_ok = (value != 6'h00) && (value <= `SAMPLES_MAX);
    end
endfunction

reg [31:0] rdata_next;
reg slverr_next;

// read data and error code for the addressed register
always @* begin
    rdata_next = 32'h00000000;
    slverr_next = 1'b0;
    if (paddr == `ADDR_CTRL) begin
        rdata_next = {12'h000, divshift_reg, 2'h0, samples_reg,
            7'h00, enable_reg};
    end else if (paddr == `ADDR_TARGET) begin
        rdata_next = {20'h00000, target_reg};
    end else if (paddr == `ADDR_FEEDBACK) begin
        rdata_next = {20'h00000, feedback};
        slverr_next = pwrite;
    end else if (paddr == `ADDR_LASTCOUNT) begin
        rdata_next = {{(32-COUNT_W){1'b0}}, last_count_reg};
        slverr_next = pwrite;
    end else if (paddr == `ADDR_SUM) begin
        rdata_next = {{(32-SUM_W){1'b0}}, sum_reg};
        slverr_next = pwrite;
    end else begin
        slverr_next = 1'b1;
    end
end

// answer stands for the one access cycle only
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready <= setup_phase;
        pslverr <= setup_phase & slverr_next;
        if (setup_phase) begin
            prdata <= rdata_next;
        end else begin
            prdata <= 32'h00000000;
        end
    end
end

// writes land at the access edge, while the request still stands
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        enable_reg <= 1'b1;
        samples_reg <= `CTRL_SAMPLES_RST;
        divshift_reg <= `CTRL_DIVSHIFT_RST;
        target_reg <= `TARGET_RST;
    end else if (access_wr) begin
        if (paddr == `ADDR_CTRL) begin
            enable_reg <= pwdata[`CTRL_EN_BIT];
            // out-of-range sample counts keep the old value
            if (samples_ok(samples_wr)) begin
                samples_reg <= samples_wr; // [RULE5]
            end
            // shift code 0..15 means divider 1..32768
            divshift_reg <= divshift_wr; // [RULE8]
        end else if (paddr == `ADDR_TARGET) begin
            target_reg <= pwdata[11:0];
        end
    end
end

// edge counting per control period
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        edge_count_reg <= {COUNT_W{1'b0}};
        last_count_reg <= {COUNT_W{1'b0}};
        wr_ptr_reg <= 5'h00;
        filled_reg <= {MAX_SAMPLES{1'b0}};
        calc_reg <= 1'b0;
    end else begin
        calc_reg <= period_end & enable_reg;
        if (period_end) begin
            // an edge in the closing cycle opens the new count
            edge_count_reg <= {{(COUNT_W-1){1'b0}},
                edge_rise & enable_reg}; // [RULE4]
            if (enable_reg) begin
                last_count_reg <= edge_count_reg;
                wr_ptr_reg <= wr_next;
                filled_reg[wr_next] <= 1'b1;
            end
        end else if (edge_rise & enable_reg &&
                     edge_count_reg != {COUNT_W{1'b1}}) begin
            edge_count_reg <= edge_count_reg + 1'b1; // [RULE4]
        end
    end
end

// history memory, no reset
always @(posedge clk) begin
    if (period_end & enable_reg) begin
        hist[wr_next] <= edge_count_reg;
    end
end

// feedback computation one cycle after the period closes
wire [SUM_W-1:0] sum_now = ring_sum(wr_ptr_reg, samples_reg); // [RULE5]
wire [SUM_W-1:0] scaled = sum_now >> divshift_reg; // [RULE6]
wire [12:0] meas_sat = (scaled > {{(SUM_W-13){1'b0}}, 13'h1fff}) ?
    13'h1fff : scaled[12:0];

// midpoint plus or minus the measurement, saturated to 12 bits
function [11:0] combine;
    input up;
    input [12:0] meas;
    reg [13:0] wide;
    begin
        if (up) begin
            wide = {2'b00, `FB_MID} + {1'b0, meas};
            combine = (wide[13:12] != 2'b00) ? `FB_MAX : wide[11:0];
        end else begin
            wide = {2'b00, `FB_MID} - {1'b0, meas};
            combine = wide[13] ? 12'h000 : wide[11:0]; // [RULE3]
        end
    end
endfunction

wire forward = (target_reg >= `FB_MID); // [RULE2]
// direction never sensed: sign comes from target alone
wire [11:0] fb_next = combine(forward, meas_sat); // [RULE1]

always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        feedback <= `FEEDBACK_RST;
        sum_reg <= {SUM_W{1'b0}};
        feedback_valid <= 1'b0;
    end else begin
        feedback_valid <= calc_reg;
        if (calc_reg) begin
            sum_reg <= sum_now;
            feedback <= fb_next; // [RULE1] [RULE3]
        end
    end
end

endmodule // tacho_pulse_count_feedback

`default_nettype wire

/* tb/tacho_props.sv */
`timescale 1ns/1ps
`default_nettype none
module tacho_props #(parameter int PERIOD_CYCLES = 200) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // result
    input wire logic [11:0] feedback,
    input wire logic feedback_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_setup; psel && !penable; endsequence
    property p_answer; s_setup |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_access; pready |-> psel && penable; endproperty
    a_access: assert property (p_access) else $error("stray ready");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("stray error");
    property p_unmap; s_setup ##0 paddr > 12'h010 |=> pslverr; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped ok");
    property p_hold; !feedback_valid |-> $stable(feedback); endproperty
    a_hold: assert property (p_hold) else $error("early change");
    property p_period; feedback_valid |-> ##PERIOD_CYCLES feedback_valid;
    endproperty
    a_period: assert property (p_period) else $error("bad period");
    property p_gap; feedback_valid |=> !feedback_valid [*8]; endproperty
    a_gap: assert property (p_gap) else $error("valid too long");
endmodule // tacho_props
`default_nettype wire

/* tb/tacho_sensor.sv */
`timescale 1ns/1ps
`default_nettype none
module tacho_sensor (
    // clock and control
    input wire logic clk,
    input wire logic on,
    input wire logic [7:0] half,
    // sensor line
    output logic tacho
);
    logic [7:0] cnt;
    initial begin
        cnt = 8'h00;
        tacho = 1'b1;
    end
    always @(posedge clk) begin
        if (!on || cnt + 8'h01 >= half) begin
            cnt <= 8'h00;
            // released line is pulled high
            tacho <= on ? ~tacho : 1'b1;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule // tacho_sensor
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin err_count++; \
$display("[ERR] %0t got %h exp %h", $time, g, x); end end
module tb;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, e, on;
    logic tacho_input, feedback_valid;
    logic [11:0] paddr, feedback;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] half;
    int err_count, n_compared;
    tacho_pulse_count_feedback #(.PERIOD_CYCLES(200)) i_dut (.clk(clk),
        .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tacho_input(tacho_input), .feedback(feedback),
        .feedback_valid(feedback_valid));
    tacho_sensor i_sensor (.clk(clk), .on(on), .half(half),
        .tacho(tacho_input));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic apb(input logic w, input logic [11:0] a, input int d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic meas(input int n, k, tgt, h, o);
        int s;
        apb(1'b1, 12'h004, tgt);
        apb(1'b1, 12'h000, 1 | (n << 8) | (k << 16));
        on <= o[0];
        half <= 8'(h);
        repeat (n + 2) @(posedge clk iff feedback_valid);
        s = o ? (n * (100 / h)) >> k : 0;
        s = (tgt >= 2048) ? 2048 + s : 2048 - s;
        s = (s > 4095) ? 4095 : ((s < 0) ? 0 : s);
        `CHK(feedback, 12'(s))
        apb(1'b0, 12'h00c, 0);
        `CHK(q, 32'(o ? 100 / h : 0))
        apb(1'b0, 12'h010, 0);
        `CHK(q, 32'(o ? n * (100 / h) : 0))
    endtask
    task automatic t_reset;
        `CHK(feedback, 12'h800)
        apb(1'b0, 12'h000, 0);
        `CHK(q, 32'h00000101)
    endtask
    task automatic t_count;
        meas(1, 0, 2048, 10, 1);
        meas(1, 0, 2047, 10, 1);
        meas(4, 0, 4095, 10, 1);
        meas(4, 2, 0, 10, 1);
    endtask
    task automatic t_sat;
        meas(32, 0, 4095, 1, 1);
        meas(32, 0, 0, 1, 1);
        meas(32, 15, 4095, 1, 1);
    endtask
    task automatic t_refuse;
        apb(1'b1, 12'h000, 32'h2101);
        apb(1'b1, 12'h000, 32'h0001);
        apb(1'b0, 12'h000, 0);
        `CHK(q[13:8], 6'h20)
        apb(1'b0, 12'h020, 0);
        `CHK(e, 1'b1)
        apb(1'b1, 12'h008, 0);
        `CHK(e, 1'b1)
        meas(1, 0, 2048, 10, 0);
    endtask
    task automatic end_sim;
        $display("errors %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        {reset_n, psel, penable, pwrite, on} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        half = 8'h0a;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_count();
        t_sat();
        t_refuse();
        end_sim();
    end
    initial begin
        #600000;
        err_count++;
        end_sim();
    end
endmodule // tb
bind tacho_pulse_count_feedback tacho_props #(.PERIOD_CYCLES(PERIOD_CYCLES))
    u_props (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .feedback(feedback),
    .feedback_valid(feedback_valid));
`default_nettype wire
